// ---- src/sdc_consts.svh ----
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SDC_IDX_CTRL_A 8'hE4
`define SDC_IDX_CTRL_B 8'hE5
`define SDC_IDX_FRAME 8'hE6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SDC_RST_CTRL_A 8'h00
`define SDC_RST_CTRL_B 8'h00
`define SDC_RST_FRAME 8'h00

// ----------------------------------------------------------------
// control/status a fields
// ----------------------------------------------------------------
`define SDC_A_ON 7
`define SDC_A_LOWPWR 6
`define SDC_A_FLAG 4
`define SDC_A_IE 3
`define SDC_A_BYPASS 2
`define SDC_A_SUPPLY 1
`define SDC_A_BLANK 0

// ----------------------------------------------------------------
// control/status b fields
// ----------------------------------------------------------------
`define SDC_B_CLKSRC 7
`define SDC_B_HALFBIAS 6
`define SDC_B_DUTY_HI 5
`define SDC_B_DUTY_LO 4
`define SDC_B_MASK_HI 3
`define SDC_B_MASK_LO 0
`define SDC_B_WMASK_SMALL 8'hF7
`define SDC_SMALL_SEG_PINS 25

// ----------------------------------------------------------------
// frame rate fields
// ----------------------------------------------------------------
`define SDC_F_TAP_HI 6
`define SDC_F_TAP_LO 4
`define SDC_F_DIV_HI 2
`define SDC_F_DIV_LO 0

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SDC_PS_MIN_LAST 12'h00F
`define SDC_PS_STEP 12'h020
`define SDC_K_LAST_DEFAULT 3'h7
`define SDC_K_LAST_THIRD 3'h5

// ----------------------------------------------------------------
// segment counts per mask code
// ----------------------------------------------------------------
`define SDC_SEG_BASE 6'h0D
`define SDC_SEG_CODE6 6'h18
`define SDC_SEG_CODE7 6'h19
`define SDC_SEG_CODE8 6'h1B
`define SDC_SEG_CODE15 6'h28

`endif

// ---- src/sdc_pkg.sv ----
package sdc_pkg;
   typedef enum logic [1:0] {
      SDC_DUTY_STATIC,
      SDC_DUTY_HALF,
      SDC_DUTY_THIRD,
      SDC_DUTY_QUARTER
   } sdc_duty_e;
   typedef logic [2:0] sdc_phase_t;
endpackage

// ---- src/sdc_frame_timer.sv ----
`timescale 1ns/10ps
`include "sdc_consts.svh"

module sdc_frame_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic tick,
   input wire logic [2:0] tapSel,
   input wire logic [2:0] divSel,
   input wire logic thirdDuty,
   output logic lcdTick,
   output logic frameStart,
   output sdc_pkg::sdc_phase_t phase
);
   logic [11:0] psCnt;
   logic [2:0] divCnt;

   // ----------------------------------------------------------------
   // tap, divider and phase decode
   // ----------------------------------------------------------------
   wire [11:0] psLast = (tapSel == 3'h0) ? `SDC_PS_MIN_LAST :
      12'((`SDC_PS_STEP << tapSel) - 12'h001);
   wire psWrap = tick && (psCnt == psLast);
   wire divWrap = psWrap && (divCnt == divSel);
   wire [2:0] kLast = thirdDuty ? `SDC_K_LAST_THIRD : `SDC_K_LAST_DEFAULT;
   wire phaseWrap = divWrap && (phase == kLast);

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         psCnt <= 12'h000;
         divCnt <= 3'h0;
         phase <= 3'h0;
         lcdTick <= 1'b0;
         frameStart <= 1'b0;
      end else begin
         if (tick) begin
            psCnt <= psWrap ? 12'h000 : 12'(psCnt + 12'h001);
         end
         if (psWrap) begin
            divCnt <= divWrap ? 3'h0 : 3'(divCnt + 3'h1);
         end
         if (divWrap) begin
            phase <= phaseWrap ? 3'h0 : 3'(phase + 3'h1);
         end
         lcdTick <= divWrap;
         frameStart <= phaseWrap;
      end
   end
endmodule

// ---- src/sdc_regs.sv ----
// Behaviour
// - enable bit starts driving; clearing it releases all pins at once.
// - low-power waveform bit takes effect at the next frame start, or at once while the enable bit is clear.
// - reserved bits of control a and frame rate read zero.
// - frame flag sets at each frame start together with the data latch.
// - interrupt request while flag, interrupt enable bit and global enable all set.
// - flag clears on vector taken or on writing one; zero leaves it.
// - with low-power waveform, flag and data latch every second frame only.
// - buffer bypass bit switches off the level buffers.
// - blank bit grounds all pins after the current frame completes.
// - clock source bit picks system clock or the external clock pin.
// - bias bit selects one-third or one-half bias except when static.
// - duty field selects one to four commons; unused commons are ports.
// - mask code sets segment pins from 13 up to 40.
// - on 25-pin variants the top mask bit reads zero.
// - prescaler taps divide by 16 up to 4096.
// - divider divides prescaler output by field value plus one.
// - frame lasts K*N*D module clocks, K six for third duty else eight.
// - blank and waveform bits are latched with the data latch, so every second frame with low-power waveform.
`timescale 1ns/10ps
`include "sdc_consts.svh"

module sdc_regs #(
   parameter int SEG_PINS = 40
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic irqAck,
   input wire logic globalIrqEn,
   input wire logic extClkPin,
   output logic [39:0] segPinOwn,
   output logic [3:0] comPinOwn,
   output logic [3:0] comSelect,
   output logic groundAll,
   output logic lowPowerWave,
   output logic bufferBypass,
   output logic supplyOff,
   output logic halfBias,
   output logic asyncClock,
   output logic latchData,
   output logic frameIrq
);
   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   function automatic logic [39:0] segMask(input logic [3:0] code);
      logic [5:0] count;
      logic [39:0] mask;
      count = 6'h00;
      mask = 40'h00_0000_0000;
      if (code < 4'h6) begin
         count = 6'(`SDC_SEG_BASE + {1'b0, code, 1'b0});
      end else if (code == 4'h6) begin
         count = `SDC_SEG_CODE6;
      end else if (code == 4'h7) begin
         count = `SDC_SEG_CODE7;
      end else if (code == 4'hF) begin
         count = `SDC_SEG_CODE15;
      end else begin
         count = 6'(`SDC_SEG_CODE8 + {1'b0, 4'(code - 4'h8), 1'b0});
      end
      for (int i = 0; i < 40; i++) begin
         mask[i] = (6'(i) < count);
      end
      return mask;
   endfunction

   function automatic logic [3:0] comMask(input logic [1:0] duty);
      case (duty)
         2'h0: comMask = 4'h1;
         2'h1: comMask = 4'h3;
         2'h2: comMask = 4'h7;
         default: comMask = 4'hF;
      endcase
   endfunction

   function automatic logic [3:0] comOneHot(input logic [2:0] ph,
                                            input logic [1:0] duty);
      logic [1:0] idx;
      idx = 2'h0;
      case (duty)
         2'h0: idx = 2'h0;
         2'h1: idx = {1'b0, ph[1]};
         2'h2: idx = (ph[2:1] == 2'h3) ? 2'h0 : ph[2:1];
         default: idx = ph[2:1];
      endcase
      return 4'(4'h1 << idx);
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic regOn;
   logic regLowPower;
   logic flag;
   logic regIe;
   logic regBypass;
   logic regSupplyOff;
   logic regBlank;
   logic [7:0] regB;
   logic [2:0] regTap;
   logic [2:0] regDiv;
   logic activeLowPower;
   logic activeBlank;
   logic lpParity;
   logic extS1;
   logic extS2;
   logic extS3;
   logic lcdTick;
   logic frameStart;
   sdc_pkg::sdc_phase_t phase;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire hitA = (paddr[11:2] == {2'h0, `SDC_IDX_CTRL_A});
   wire hitB = (paddr[11:2] == {2'h0, `SDC_IDX_CTRL_B});
   wire hitF = (paddr[11:2] == {2'h0, `SDC_IDX_FRAME});
   wire mapped = hitA || hitB || hitF;
   wire access = psel && penable && pready;
   wire wrA = access && pwrite && hitA;
   wire wrB = access && pwrite && hitB;
   wire wrF = access && pwrite && hitF;
   wire [7:0] wMaskB = (SEG_PINS > `SDC_SMALL_SEG_PINS) ? 8'hFF :
      `SDC_B_WMASK_SMALL;
   wire [7:0] rdA = {regOn, regLowPower, 1'b0, flag, regIe,
      regBypass, regSupplyOff, regBlank};
   wire [7:0] rdF = {1'b0, regTap, 1'b0, regDiv};
   wire [7:0] rdData = hitA ? rdA : hitB ? regB : hitF ? rdF : 8'h00;
   wire [1:0] duty = regB[`SDC_B_DUTY_HI:`SDC_B_DUTY_LO];
   wire thirdDuty = (duty == 2'(sdc_pkg::SDC_DUTY_THIRD));

   // ----------------------------------------------------------------
   // clock source and frame events
   // ----------------------------------------------------------------
   wire extTick = extS2 && !extS3;
   wire modTick = regB[`SDC_B_CLKSRC] ? extTick : 1'b1;
   wire latchEv = frameStart && (!activeLowPower || lpParity);
   wire flagClr = (wrA && pwdata[`SDC_A_FLAG]) || irqAck;

   // ----------------------------------------------------------------
   // apb slave: one wait state, then answer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= {24'h00_0000, rdData};
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         {regOn, regLowPower} <= 2'(`SDC_RST_CTRL_A >> `SDC_A_LOWPWR);
         regIe <= 1'b0;
         regBypass <= 1'b0;
         regSupplyOff <= 1'b0;
         regBlank <= 1'b0;
         regB <= `SDC_RST_CTRL_B;
         {regTap, regDiv} <= 6'h00;
      end else begin
         if (wrA) begin
            regOn <= pwdata[`SDC_A_ON];
            regLowPower <= pwdata[`SDC_A_LOWPWR];
            regIe <= pwdata[`SDC_A_IE];
            regBypass <= pwdata[`SDC_A_BYPASS];
            regSupplyOff <= pwdata[`SDC_A_SUPPLY];
            regBlank <= pwdata[`SDC_A_BLANK];
         end
         if (wrB) begin
            regB <= pwdata[7:0] & wMaskB;
         end
         if (wrF) begin
            regTap <= pwdata[`SDC_F_TAP_HI:`SDC_F_TAP_LO];
            regDiv <= pwdata[`SDC_F_DIV_HI:`SDC_F_DIV_LO];
         end
      end
   end

   // ----------------------------------------------------------------
   // frame flag and latched drive state
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         flag <= 1'b0;
         lpParity <= 1'b0;
         activeLowPower <= 1'b0;
         activeBlank <= 1'b0;
      end else begin
         flag <= latchEv || (flag && !flagClr);
         if (!regOn) begin
            lpParity <= 1'b0;
            activeLowPower <= regLowPower;
            activeBlank <= regBlank;
         end else begin
            if (frameStart) begin
               lpParity <= !lpParity;
            end
            if (latchEv) begin
               activeLowPower <= regLowPower;
               activeBlank <= regBlank;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // external clock synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         extS1 <= 1'b0;
         extS2 <= 1'b0;
         extS3 <= 1'b0;
      end else begin
         extS1 <= extClkPin;
         extS2 <= extS1;
         extS3 <= extS2;
      end
   end

   sdc_frame_timer sdc_frame_timer_inst (
      .clk(clk),
      .rst(rst),
      .run(regOn),
      .tick(modTick),
      .tapSel(regTap),
      .divSel(regDiv),
      .thirdDuty(thirdDuty),
      .lcdTick(lcdTick),
      .frameStart(frameStart),
      .phase(phase)
   );

   // ----------------------------------------------------------------
   // pin drive outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         segPinOwn <= 40'h00_0000_0000;
         comPinOwn <= 4'h0;
         comSelect <= 4'h0;
         groundAll <= 1'b0;
         lowPowerWave <= 1'b0;
         bufferBypass <= 1'b0;
         supplyOff <= 1'b0;
         halfBias <= 1'b0;
         asyncClock <= 1'b0;
         latchData <= 1'b0;
         frameIrq <= 1'b0;
      end else begin
         segPinOwn <= regOn ? segMask(regB[3:0]) : 40'h00_0000_0000;
         comPinOwn <= regOn ? comMask(duty) : 4'h0;
         comSelect <= (regOn && !activeBlank) ? comOneHot(phase, duty) :
            4'h0;
         groundAll <= regOn && activeBlank;
         lowPowerWave <= activeLowPower;
         bufferBypass <= regBypass;
         supplyOff <= regSupplyOff;
         halfBias <= regB[`SDC_B_HALFBIAS] && (duty != 2'h0);
         asyncClock <= regB[`SDC_B_CLKSRC];
         latchData <= latchEv;
         frameIrq <= flag && regIe && globalIrqEn;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_flag_set: assert property (latchEv |=> flag && latchData)
      else $error("frame flag or latch missing after frame start");
   a_flag_clear: assert property (
      wrA && pwdata[`SDC_A_FLAG] && !latchEv |=> !flag)
      else $error("write one did not clear frame flag");
   a_flag_keep: assert property (
      flag && wrA && !pwdata[`SDC_A_FLAG] && !irqAck |=> flag)
      else $error("write zero cleared frame flag");
   a_irq_raise: assert property (
      flag && regIe && globalIrqEn ##1 flag |-> frameIrq)
      else $error("interrupt request not raised");
   a_irq_masked: assert property (!globalIrqEn |=> !frameIrq)
      else $error("interrupt request while globally masked");
   a_read_reserved: assert property (
      psel && penable && !pready && hitA |=> prdata[5] == 1'b0)
      else $error("reserved bit read as one");
   a_off_release: assert property (
      $fell(regOn) |=> segPinOwn == 40'h0 && comPinOwn == 4'h0)
      else $error("pins not released when controller off");
   a_off_select: assert property (
      !regOn |=> comSelect == 4'h0 && !groundAll)
      else $error("common driven while controller off");
   a_lp_every_second: assert property (
      latchEv && activeLowPower |-> lpParity)
      else $error("low power latch on odd frame");
   a_wave_at_frame: assert property (
      regOn && $past(regOn) && $changed(activeLowPower) |-> $past(latchEv))
      else $error("waveform changed between frames");
   a_blank_at_frame: assert property (
      regOn && $past(regOn) && $rose(activeBlank) |-> $past(latchEv))
      else $error("blanking took effect mid frame");
   a_blank_select: assert property (activeBlank |=> comSelect == 4'h0)
      else $error("common selected while blanked");
   a_static_com: assert property (
      regOn && duty == 2'h0 |=> comPinOwn == 4'h1)
      else $error("static duty uses wrong commons");
   a_static_bias: assert property (duty == 2'h0 |=> !halfBias)
      else $error("half bias reported for static duty");
   a_seg_min: assert property (
      regOn && regB[3:0] == 4'h0 |=> segPinOwn == 40'h00_0000_1FFF)
      else $error("mask code zero not thirteen segments");
   a_ext_gate: assert property (
      regB[`SDC_B_CLKSRC] && !extTick |-> !modTick)
      else $error("module tick without external edge");
   a_frame_on_tick: assert property (frameStart |-> lcdTick)
      else $error("frame start off the divided clock");

   c_frame_latch: cover property (latchEv ##1 flag);
   c_blank_enter: cover property ($rose(groundAll));
   c_irq_taken: cover property (frameIrq ##1 irqAck);
   c_lowpower_skip: cover property (frameStart && activeLowPower && !latchEv);
   c_ext_frame: cover property (asyncClock && latchData);
endmodule

// ---- bench/sdc_glass_model.sv ----
`timescale 1ns/10ps

// ----------------------------------------------------------------
// passive segment glass: flags any illegal drive it sees
// ----------------------------------------------------------------
module sdc_glass_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [39:0] segPinOwn,
   input wire logic [3:0] comPinOwn,
   input wire logic [3:0] comSelect,
   input wire logic groundAll,
   output logic fault
);
   logic badCom;
   logic badGround;
   logic badOwn;

   // a common may only be active on an owned pin, one at a time
   assign badCom = ((comSelect & ~comPinOwn) != 4'h0) ||
                   ($countones(comSelect) > 1);
   // grounded glass sees no active common
   assign badGround = groundAll && (comSelect != 4'h0);
   // segments are never owned while no common is owned
   assign badOwn = (segPinOwn != 40'h0) && (comPinOwn == 4'h0);

   always @(posedge clk) begin
      if (rst) begin
         fault <= 1'b0;
      end else if (badCom || badGround || badOwn) begin
         fault <= 1'b1;
      end
   end
endmodule

// ---- bench/test_segment_display_ctrl_regs.sv ----
`timescale 1ns/10ps
`include "sdc_consts.svh"
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin \
   fail_count++; $display("BAD %0t %s", $time, m); end end

module test_segment_display_ctrl_regs;
   localparam logic [11:0] ADDR_A = {2'h0, `SDC_IDX_CTRL_A, 2'h0};
   localparam logic [11:0] ADDR_B = {2'h0, `SDC_IDX_CTRL_B, 2'h0};
   localparam logic [11:0] ADDR_F = {2'h0, `SDC_IDX_FRAME, 2'h0};
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic irqAck, globalIrqEn, extClkPin, groundAll, lowPowerWave;
   logic bufferBypass, supplyOff, halfBias, asyncClock, latchData;
   logic frameIrq, glassFault, err, hb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [39:0] segPinOwn;
   logic [3:0] comPinOwn, comSelect;
   logic [7:0] rd;
   logic [1:0] du;
   int fail_count, n_compared, cycles, extDiv, per, dv;

   sdc_regs #(.SEG_PINS(40)) sdc_regs_inst (.clk(clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irqAck(irqAck), .globalIrqEn(globalIrqEn),
      .extClkPin(extClkPin), .segPinOwn(segPinOwn),
      .comPinOwn(comPinOwn), .comSelect(comSelect),
      .groundAll(groundAll), .lowPowerWave(lowPowerWave),
      .bufferBypass(bufferBypass), .supplyOff(supplyOff),
      .halfBias(halfBias), .asyncClock(asyncClock),
      .latchData(latchData), .frameIrq(frameIrq));

   sdc_glass_model sdc_glass_model_inst (.clk(clk), .rst(rst),
      .segPinOwn(segPinOwn), .comPinOwn(comPinOwn),
      .comSelect(comSelect), .groundAll(groundAll), .fault(glassFault));

   // ----------------------------------------------------------------
   // clock, external clock and run limit
   // ----------------------------------------------------------------
   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      extDiv <= extDiv + 1;
      extClkPin <= extDiv[2];
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         print_verdict();
      end
   end

   // ----------------------------------------------------------------
   // tasks and expectations
   // ----------------------------------------------------------------
   task print_verdict();
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK(pready, 1'b1, "no ready")
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [7:0] e,
                        input string m);
      apb(1'b0, a, 8'h00);
      `CHK(rd, e, m)
   endtask

   task automatic wait_latch();
      per = 0;
      do begin
         @(posedge clk);
         per++;
      end while (latchData !== 1'b1 && per < 40000);
      if (per >= 40000) fail_count++;
   endtask

   task automatic meas(input int e, input string m);
      wait_latch();
      wait_latch();
      wait_latch();
      `CHK(per, e, m)
   endtask

   function automatic int frame_len(input int tap, input int d,
                                    input logic [1:0] u, input int mult);
      int n;
      int k;
      n = (tap == 0) ? 16 : (32 << tap);
      k = (u == sdc_pkg::SDC_DUTY_THIRD) ? 6 : 8;
      return k * n * (d + 1) * mult;
   endfunction

   function automatic logic [39:0] seg_mask(input int c);
      int n;
      logic [40:0] t;
      if (c <= 5) n = 13 + 2 * c;
      else if (c == 6) n = 24;
      else if (c == 7) n = 25;
      else if (c == 15) n = 40;
      else n = 27 + 2 * (c - 8);
      t = (41'h1 << n) - 41'h1;
      return t[39:0];
   endfunction

   function automatic logic [3:0] com_mask(input logic [1:0] u);
      logic [4:0] t;
      t = (5'h1 << (u + 1)) - 5'h1;
      return t[3:0];
   endfunction

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, irqAck} = 4'h0;
      globalIrqEn = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      {fail_count, n_compared} = 64'h0;
      void'($urandom(17557));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rdchk(ADDR_A, `SDC_RST_CTRL_A, "reset a");
      rdchk(ADDR_B, `SDC_RST_CTRL_B, "reset b");
      rdchk(ADDR_F, `SDC_RST_FRAME, "reset frame");
      wr(ADDR_F, 8'hFF);
      rdchk(ADDR_F, 8'h77, "frame reserved");
      wr(ADDR_A, 8'h26);
      rdchk(ADDR_A, 8'h06, "a reserved");
      `CHK(bufferBypass, 1'b1, "bypass")
      `CHK(supplyOff, 1'b1, "supply off")
      apb(1'b0, 12'h39C, 8'h00);
      `CHK({err, rd}, 9'h100, "unmapped")
      wr(ADDR_F, 8'h00);
      wr(ADDR_A, 8'h82);
      for (int c = 0; c < 16; c++) begin
         du = 2'($urandom_range(3));
         hb = 1'($urandom_range(1));
         wr(ADDR_B, {1'b0, hb, du, c[3:0]});
         @(posedge clk);
         #1;
         `CHK(segPinOwn, seg_mask(c), "segment pins")
         `CHK(comPinOwn, com_mask(du), "common pins")
         `CHK(halfBias, hb & (du != 2'h0), "bias")
         rdchk(ADDR_B, {1'b0, hb, du, c[3:0]}, "b readback");
      end
      wr(ADDR_A, 8'h00);
      @(posedge clk);
      #1;
      `CHK({segPinOwn, comPinOwn}, 44'h0, "pins released")
      wr(ADDR_B, 8'h3F);
      wr(ADDR_A, 8'h88);
      wait_latch();
      wr(ADDR_A, 8'h98);
      @(posedge latchData);
      #1;
      `CHK(frameIrq, 1'b0, "irq early")
      @(posedge clk);
      #1;
      `CHK(frameIrq, 1'b1, "irq raised")
      rdchk(ADDR_A, 8'h98, "flag set");
      wr(ADDR_A, 8'h88);
      rdchk(ADDR_A, 8'h98, "flag kept");
      wr(ADDR_A, 8'h98);
      rdchk(ADDR_A, 8'h88, "flag cleared");
      wait_latch();
      @(posedge clk);
      irqAck <= 1'b1;
      @(posedge clk);
      irqAck <= 1'b0;
      rdchk(ADDR_A, 8'h88, "flag acked");
      globalIrqEn <= 1'b0;
      wait_latch();
      #1;
      `CHK(frameIrq, 1'b0, "irq masked")
      @(posedge clk);
      globalIrqEn <= 1'b1;
      wait_latch();
      wr(ADDR_A, 8'hC0);
      @(posedge clk);
      #1;
      `CHK(lowPowerWave, 1'b0, "wave early")
      wait_latch();
      #1;
      `CHK(lowPowerWave, 1'b1, "wave latched")
      meas(frame_len(0, 0, 2'h3, 2), "low power period");
      wr(ADDR_A, 8'h80);
      wait_latch();
      wr(ADDR_A, 8'h81);
      @(posedge clk);
      #1;
      `CHK(groundAll, 1'b0, "blank early")
      wait_latch();
      #1;
      `CHK({groundAll, comSelect}, 5'h10, "blanked")
      wr(ADDR_A, 8'h80);
      wait_latch();
      #1;
      `CHK(groundAll, 1'b0, "unblanked")
      for (int t = 0; t < 4; t++) begin
         dv = $urandom_range(1);
         du = (t == 1) ? 2'h2 : 2'($urandom_range(3));
         wr(ADDR_F, {1'b0, t[2:0], 1'b0, dv[2:0]});
         wr(ADDR_B, {2'h0, du, 4'h0});
         meas(frame_len(t, dv, du, 1), "frame period");
      end
      wr(ADDR_F, 8'h00);
      wr(ADDR_B, 8'hB0);
      meas(frame_len(0, 0, 2'h3, 8), "ext clock period");
      `CHK(asyncClock, 1'b1, "clock source")
      `CHK(glassFault, 1'b0, "glass drive")
      print_verdict();
   end
endmodule
